// *** design/ipsc_cfg.svh ***
`ifndef IPSC_CFG_SVH
`define IPSC_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define IPSC_OFF_BUF 12'h000
`define IPSC_OFF_RELOAD 12'h004
`define IPSC_OFF_CTRL1 12'h008
`define IPSC_OFF_CTRL2 12'h00c
`define IPSC_OFF_STATUS 12'h010
`define IPSC_OFF_IRQ_STAT 12'h014
`define IPSC_OFF_IRQ_MASK 12'h018

// ****************************************
// control one fields
// ****************************************
`define IPSC_C1_WRITE_COLLISION 7
`define IPSC_C1_OVF 6
`define IPSC_C1_EN 5
`define IPSC_C1_CKP 4
`define IPSC_C1_MODE3 3

// ****************************************
// control two fields
// ****************************************
`define IPSC_C2_GENERAL_CALL_ENABLE 7
`define IPSC_C2_ACK_RECEIVED_STATUS 6
`define IPSC_C2_ACK_SEQUENCE_ENABLE 4
`define IPSC_C2_RECEIVE_ENABLE 3
`define IPSC_C2_PEN 2
`define IPSC_C2_REPEAT_START_ENABLE 1
`define IPSC_C2_SEN 0
`define IPSC_C2_SEQ_MASK 8'h17

// ****************************************
// status and irq fields
// ****************************************
`define IPSC_ST_STOP 4
`define IPSC_ST_BF 0
`define IPSC_IRQ_SSP 0
`define IPSC_IRQ_BCL 1

// ****************************************
// reset values
// ****************************************
`define IPSC_RST_BYTE 8'h00
`define IPSC_RST_CTRL1 8'h00

`endif

// *** design/ipsc_pkg.sv ***
package ipsc_pkg;
    // gray coded stop walk
    typedef enum logic [2:0] {
        IPSC_IDLE = 3'b000,
        IPSC_SDA_LOW = 3'b001,
        IPSC_SCL_REL = 3'b011,
        IPSC_COUNT_HI = 3'b010,
        IPSC_SDA_REL = 3'b110,
        IPSC_FINAL = 3'b111
    } ipsc_state_type;
endpackage

// *** design/ipsc_stop.sv ***
`include "ipsc_cfg.svh"
// Notes on behaviour
// - after sda is released and the baud count expires, sda sampled low is a collision.
// - once scl is released and sampled high, scl sampled low before sda may rise is a collision.
// - the stop starts with sda driven low and scl is released only once sda reads low.
// - after releasing scl wait for scl high, then load the counter from reload bits 6..0 and count to zero.
// - when the counter reaches zero after sda is released, sda is sampled to judge a collision.
// - in slave mode control two bits 5..1 read and write as address mask bits; the code keeps them as plain control two bits in every mode.
// - the mask register shares the reload offset and is reached only in slave 7-bit masking mode.
// - a collision aborts the sequence, releases both lines and clears the sequence bits.
// - any bus collision sets the bus collision flag and returns the port to idle.
// - sda high while scl high at stop end sets the stop detected status bit 4.
// - one baud period after a good stop the stop enable clears and the port irq flag sets.
module ipsc_stop (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // i2c lines, open drain
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_out,
    // interrupt
    output logic irq_out
);
    // ****************************************
    // declarations
    // ****************************************
    logic [1:0] sda_sync_reg, sda_sync_next;
    logic [1:0] scl_sync_reg, scl_sync_next;
    ipsc_pkg::ipsc_state_type state_reg, state_next;
    logic [6:0] baud_down_counter_reg, baud_down_counter_next;
    logic sda_low_reg, sda_low_next;
    logic scl_low_reg, scl_low_next;
    logic [7:0] receive_transmit_buffer_reg, receive_transmit_buffer_next;
    logic [7:0] address_or_baud_reload_reg, address_or_baud_reload_next;
    logic [7:0] slave_address_mask_reg, slave_address_mask_next;
    logic [7:0] port_control_one_reg, port_control_one_next;
    logic [7:0] port_control_two_reg, port_control_two_next;
    logic [7:0] port_status_reg, port_status_next;
    logic [1:0] irq_stat_reg, irq_stat_next;
    logic [1:0] irq_mask_reg, irq_mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic ack_reg, ack_next;
    logic sda_s, scl_s, slave_mode, mask_mode, wr_acc, rd_acc, collide, stop_done, cnt_zero;
    logic [7:0] ctrl2_view;

    // ****************************************
    // decode
    // ****************************************
    assign sda_s = sda_sync_reg[1];
    assign scl_s = scl_sync_reg[1];
    assign slave_mode = ~port_control_one_reg[`IPSC_C1_MODE3];
    // modes 0110/0111 chosen as the 7-bit masking slave modes
    assign mask_mode = port_control_one_reg[3:1] == 3'h3;
    // one wait state: read data is loaded first, then the ready edge hands it over
    assign wr_acc = psel_in & penable_in & pwrite_in & ack_reg & clk_en_in;
    assign rd_acc = psel_in & penable_in & ~pwrite_in & ~ack_reg & clk_en_in;
    assign cnt_zero = baud_down_counter_reg == 7'h00;
    assign ctrl2_view = port_control_two_reg;
    assign pready_out = ack_reg;
    assign pslverr_out = 1'b0;
    assign prdata_out = prdata_reg;
    // open drain: output fixed low, enable pulls the line
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe_out = sda_low_reg;
    assign scl_oe_out = scl_low_reg;
    assign irq_out = |(irq_stat_reg & irq_mask_reg);

    // ****************************************
    // stop sequence
    // ****************************************
    always_comb begin
        sda_sync_next = {sda_sync_reg[0], sda_in};
        scl_sync_next = {scl_sync_reg[0], scl_in};
        state_next = state_reg;
        baud_down_counter_next = baud_down_counter_reg;
        sda_low_next = sda_low_reg;
        scl_low_next = scl_low_reg;
        collide = 1'b0;
        stop_done = 1'b0;
        case (state_reg)
            ipsc_pkg::IPSC_IDLE: begin
                if (port_control_two_reg[`IPSC_C2_PEN] && port_control_one_reg[`IPSC_C1_EN] && !slave_mode) begin
                    sda_low_next = 1'b1;
                    scl_low_next = 1'b1;
                    state_next = ipsc_pkg::IPSC_SDA_LOW;
                end
            end
            ipsc_pkg::IPSC_SDA_LOW: begin
                if (!sda_s) begin
                    scl_low_next = 1'b0;
                    state_next = ipsc_pkg::IPSC_SCL_REL;
                end
            end
            ipsc_pkg::IPSC_SCL_REL: begin
                // stretching: hold here while any device keeps scl low
                if (scl_s) begin
                    baud_down_counter_next = address_or_baud_reload_reg[6:0];
                    state_next = ipsc_pkg::IPSC_COUNT_HI;
                end
            end
            ipsc_pkg::IPSC_COUNT_HI: begin
                if (!scl_s) begin
                    collide = 1'b1;
                end else if (cnt_zero) begin
                    sda_low_next = 1'b0;
                    baud_down_counter_next = address_or_baud_reload_reg[6:0];
                    state_next = ipsc_pkg::IPSC_SDA_REL;
                end else begin
                    baud_down_counter_next = baud_down_counter_reg - 7'h01;
                end
            end
            ipsc_pkg::IPSC_SDA_REL: begin
                if (!cnt_zero) begin
                    baud_down_counter_next = baud_down_counter_reg - 7'h01;
                end else if (!sda_s) begin
                    collide = 1'b1;
                end else begin
                    baud_down_counter_next = address_or_baud_reload_reg[6:0];
                    state_next = ipsc_pkg::IPSC_FINAL;
                end
            end
            ipsc_pkg::IPSC_FINAL: begin
                if (cnt_zero) begin
                    stop_done = 1'b1;
                    state_next = ipsc_pkg::IPSC_IDLE;
                end else begin
                    baud_down_counter_next = baud_down_counter_reg - 7'h01;
                end
            end
            default: begin
                state_next = ipsc_pkg::IPSC_IDLE;
            end
        endcase
        if (collide || !port_control_one_reg[`IPSC_C1_EN]) begin
            sda_low_next = 1'b0;
            scl_low_next = 1'b0;
            state_next = ipsc_pkg::IPSC_IDLE;
        end
    end

    // ****************************************
    // registers and bus
    // ****************************************
    always_comb begin
        receive_transmit_buffer_next = receive_transmit_buffer_reg;
        address_or_baud_reload_next = address_or_baud_reload_reg;
        slave_address_mask_next = slave_address_mask_reg;
        port_control_one_next = port_control_one_reg;
        port_control_two_next = port_control_two_reg;
        port_status_next = port_status_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        prdata_next = prdata_reg;
        ack_next = psel_in & penable_in & ~ack_reg;
        if (wr_acc) begin
            case (paddr_in)
                `IPSC_OFF_BUF: begin
                    // writes during a stop are dropped and flagged
                    if (state_reg != ipsc_pkg::IPSC_IDLE) begin
                        port_control_one_next[`IPSC_C1_WRITE_COLLISION] = 1'b1;
                    end else begin
                        receive_transmit_buffer_next = pwdata_in[7:0];
                        port_status_next[`IPSC_ST_BF] = 1'b1;
                    end
                end
                `IPSC_OFF_RELOAD: begin
                    if (slave_mode && mask_mode) begin
                        slave_address_mask_next = pwdata_in[7:0];
                    end else begin
                        address_or_baud_reload_next = pwdata_in[7:0];
                    end
                end
                `IPSC_OFF_CTRL1: port_control_one_next = pwdata_in[7:0];
                `IPSC_OFF_CTRL2: begin
                    // ack_received_status is hardware owned
                    port_control_two_next = {pwdata_in[7], port_control_two_reg[6], pwdata_in[5:0]};
                end
                `IPSC_OFF_IRQ_STAT: irq_stat_next = irq_stat_reg & ~pwdata_in[1:0];
                `IPSC_OFF_IRQ_MASK: irq_mask_next = pwdata_in[1:0];
                default: begin
                end
            endcase
        end
        if (rd_acc) begin
            case (paddr_in)
                `IPSC_OFF_BUF: prdata_next = {24'h000000, receive_transmit_buffer_reg};
                `IPSC_OFF_RELOAD: prdata_next = {24'h000000, (slave_mode && mask_mode) ?
                    slave_address_mask_reg : address_or_baud_reload_reg};
                `IPSC_OFF_CTRL1: prdata_next = {24'h000000, port_control_one_reg};
                `IPSC_OFF_CTRL2: prdata_next = {24'h000000, ctrl2_view};
                `IPSC_OFF_STATUS: prdata_next = {24'h000000, port_status_reg};
                `IPSC_OFF_IRQ_STAT: prdata_next = {30'h00000000, irq_stat_reg};
                `IPSC_OFF_IRQ_MASK: prdata_next = {30'h00000000, irq_mask_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
        if (collide) begin
            port_control_two_next = port_control_two_next & ~`IPSC_C2_SEQ_MASK;
            irq_stat_next[`IPSC_IRQ_BCL] = 1'b1;
        end
        if (state_reg == ipsc_pkg::IPSC_SDA_REL && cnt_zero && sda_s && scl_s) begin
            port_status_next[`IPSC_ST_STOP] = 1'b1;
        end
        if (stop_done) begin
            port_control_two_next[`IPSC_C2_PEN] = 1'b0;
            irq_stat_next[`IPSC_IRQ_SSP] = 1'b1;
        end
        if (!port_control_one_reg[`IPSC_C1_EN]) begin
            port_status_next[`IPSC_ST_STOP] = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sda_sync_reg <= 2'h3;
            scl_sync_reg <= 2'h3;
            state_reg <= ipsc_pkg::IPSC_IDLE;
            baud_down_counter_reg <= 7'h00;
            sda_low_reg <= 1'b0;
            scl_low_reg <= 1'b0;
            receive_transmit_buffer_reg <= `IPSC_RST_BYTE;
            address_or_baud_reload_reg <= `IPSC_RST_BYTE;
            slave_address_mask_reg <= `IPSC_RST_BYTE;
            port_control_one_reg <= `IPSC_RST_CTRL1;
            port_control_two_reg <= `IPSC_RST_BYTE;
            port_status_reg <= `IPSC_RST_BYTE;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            prdata_reg <= 32'h00000000;
            ack_reg <= 1'b0;
        end else if (clk_en_in) begin
            ack_reg <= ack_next;
            sda_sync_reg <= sda_sync_next;
            scl_sync_reg <= scl_sync_next;
            state_reg <= state_next;
            baud_down_counter_reg <= baud_down_counter_next;
            sda_low_reg <= sda_low_next;
            scl_low_reg <= scl_low_next;
            receive_transmit_buffer_reg <= receive_transmit_buffer_next;
            address_or_baud_reload_reg <= address_or_baud_reload_next;
            slave_address_mask_reg <= slave_address_mask_next;
            port_control_one_reg <= port_control_one_next;
            port_control_two_reg <= port_control_two_next;
            port_status_reg <= port_status_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg <= prdata_next;
        end
    end
endmodule

// *** test/ipsc_bus_peer.sv ***
module ipsc_bus_peer (
    // design side
    input wire logic sda_oe_in,
    input wire logic sda_dat_in,
    input wire logic scl_oe_in,
    input wire logic scl_dat_in,
    // other master and line levels
    input wire logic hold_sda_in,
    input wire logic hold_scl_in,
    output logic sda_out,
    output logic scl_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // wired and with pull-ups
    // ****************************************
    assign sda_out = (sda_oe_in ? sda_dat_in : 1'b1) && !hold_sda_in;
    assign scl_out = (scl_oe_in ? scl_dat_in : 1'b1) && !hold_scl_in;
endmodule

// *** test/ipsc_stop_sva.sv ***
module ipsc_stop_sva (
    // clock and bus control
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    // answers, lines, irq
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // stop sequence, apb ready and freeze checks
    // ****************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    sequence s_stop_live;
        sda_oe_out && !scl_oe_out;
    endsequence
    property p_rst_quiet;
        $fell(reset_in) |-> !sda_oe_out && !scl_oe_out && !irq_out;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("lines or irq active after reset");
    property p_low_only;
        sda_out == 1'b0 && scl_out == 1'b0;
    endproperty
    a_low_only: assert property (p_low_only) else $error("line driven high");
    property p_start_pair;
        $rose(scl_oe_out) |-> $rose(sda_oe_out);
    endproperty
    a_start_pair: assert property (p_start_pair) else $error("scl pulled without sda");
    // sync delay means sda must have read low a cycle back
    property p_scl_wait;
        $fell(scl_oe_out) && sda_oe_out |-> $past(sda_oe_out, 2) && !$past(sda_in);
    endproperty
    a_scl_wait: assert property (p_scl_wait) else $error("scl released before sda low");
    property p_release_order;
        $fell(sda_oe_out) |-> !scl_oe_out;
    endproperty
    a_release_order: assert property (p_release_order) else $error("sda released while scl held");
    property p_scl_collide;
        s_stop_live ##1 (sda_oe_out && $fell(scl_in)) |-> ##[1:4] !sda_oe_out;
    endproperty
    a_scl_collide: assert property (p_scl_collide) else $error("scl low not aborted");
    property p_ready;
        psel_in && penable_in && !pready_out && clk_en_in |=> pready_out && !pslverr_out;
    endproperty
    a_ready: assert property (p_ready) else $error("apb access not ready");
    property p_freeze;
        !clk_en_in |=> $stable(sda_oe_out) && $stable(scl_oe_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("lines moved while frozen");
endmodule

bind ipsc_stop ipsc_stop_sva u_sva (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe_out(scl_oe_out), .irq_out(irq_out));

// *** test/test_ipsc_stop.sv ***
`include "ipsc_cfg.svh"
module test_ipsc_stop;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ipsc_row_type;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out, rd;
    logic pready_out, pslverr_out, sda_in, sda_out, sda_oe_out, scl_in, scl_out, scl_oe_out, irq_out;
    logic hold_sda = 1'b0;
    logic hold_scl = 1'b0;
    int failures = 0;
    int checks = 0;
    int n, a0, b0, a1, b1;
    // slave mode first; control two bits 5..1 read back as plain bits
    ipsc_row_type rows [9] = '{'{`IPSC_OFF_CTRL1, 32'h0, 32'h0}, '{`IPSC_OFF_CTRL2, 32'h3e, 32'h3e},
        '{`IPSC_OFF_CTRL2, 32'h0, 32'h0}, '{`IPSC_OFF_RELOAD, 32'hff85, 32'h85},
        '{`IPSC_OFF_CTRL1, 32'h06, 32'h06}, '{`IPSC_OFF_RELOAD, 32'h5c, 32'h5c},
        '{`IPSC_OFF_IRQ_MASK, 32'h3, 32'h3}, '{12'h01c, 32'hff, 32'h0}, '{`IPSC_OFF_CTRL1, 32'h28, 32'h28}};
    always #5 clk_in = ~clk_in;
    ipsc_stop DUT (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .scl_in(scl_in), .scl_out(scl_out),
        .scl_oe_out(scl_oe_out), .irq_out(irq_out));
    ipsc_bus_peer u_peer (.sda_oe_in(sda_oe_out), .sda_dat_in(sda_out), .scl_oe_in(scl_oe_out),
        .scl_dat_in(scl_out), .hold_sda_in(hold_sda), .hold_scl_in(hold_scl), .sda_out(sda_in), .scl_out(scl_in));
    // ****************************************
    // tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // read data is taken at the edge where ready is seen high
    task apb(input logic [11:0] a, input logic [31:0] d, input logic w, output logic [31:0] r);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1) @(posedge clk_in);
        r = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, d, 1'b1, rd);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(a, 32'h0, 1'b0, rd);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task wt(input int s, input logic v, output int k);
        logic [2:0] x;
        for (k = 1; k < 500; k++) begin
            @(posedge clk_in);
            x = {irq_out, scl_oe_out, sda_oe_out};
            if (x[s] === v) return;
        end
        chk($sformatf("wait %0d", s), 32'(v), 32'(!v));
    endtask
    task stop_run(input logic [7:0] rl, input int lag, output int a, output int b);
        wr(`IPSC_OFF_RELOAD, {24'h0, rl});
        hold_scl <= (lag > 0);
        wr(`IPSC_OFF_CTRL2, 32'h04);
        wt(1, 1'b0, n);
        if (lag > 0) begin
            wr(`IPSC_OFF_BUF, 32'h5a);
            repeat (lag) @(posedge clk_in);
            chk("stretch", 32'h2, {30'h0, sda_oe_out, scl_oe_out}); // still waiting
            hold_scl <= 1'b0;
            @(posedge clk_in);
        end
        wt(0, 1'b0, a);
        wt(2, 1'b1, b);
        rdc(`IPSC_OFF_STATUS, 32'h10); // stop seen
        rdc(`IPSC_OFF_CTRL2, 32'h00); // enable cleared
        rdc(`IPSC_OFF_IRQ_STAT, 32'h01); // port flag
        rdc(`IPSC_OFF_CTRL1, lag > 0 ? 32'ha8 : 32'h28);
        rdc(`IPSC_OFF_BUF, 32'h00);
        wr(`IPSC_OFF_IRQ_STAT, 32'h01);
        chk("irq", 32'h0, {31'h0, irq_out});
        $display("stop run reload %0d done", rl);
    endtask
    task coll(input int m);
        wr(`IPSC_OFF_CTRL2, 32'h04);
        wt(1, 1'b0, n);
        if (m == 0) wt(0, 1'b0, n);
        else repeat (6) @(posedge clk_in);
        hold_sda <= (m == 0);
        hold_scl <= (m != 0);
        wt(2, 1'b1, n);
        repeat (2) @(posedge clk_in);
        chk("lines", 32'h0, {30'h0, sda_oe_out, scl_oe_out}); // both released
        rdc(`IPSC_OFF_IRQ_STAT, 32'h02); // collision flag
        rdc(`IPSC_OFF_CTRL2, 32'h00); // sequence bits cleared
        wr(`IPSC_OFF_IRQ_MASK, 32'h01);
        chk("masked irq", 32'h0, {31'h0, irq_out});
        wr(`IPSC_OFF_IRQ_MASK, 32'h03);
        chk("unmasked irq", 32'h1, {31'h0, irq_out});
        wr(`IPSC_OFF_IRQ_STAT, 32'h02);
        chk("cleared irq", 32'h0, {31'h0, irq_out});
        hold_sda <= 1'b0;
        hold_scl <= 1'b0;
        repeat (4) @(posedge clk_in);
        wr(`IPSC_OFF_IRQ_STAT, 32'h03);
        $display("collision case %0d done", m);
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e); // mask bits and shared offset
        end
        rdc(`IPSC_OFF_RELOAD, 32'h85); // mask write left reload alone
        $display("register rows done");
        stop_run(8'h03, 0, a0, b0);
        stop_run(8'h0a, 20, a1, b1);
        chk("scl to sda gap", 32'd7, 32'(a1 - a0)); // count from reload
        chk("sda to irq gap", 32'd14, 32'(b1 - b0)); // one more period
        coll(0);
        coll(1);
        wr(`IPSC_OFF_CTRL2, 32'h04);
        wt(1, 1'b0, n);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        chk("reset lines", 32'h0, {29'h0, irq_out, sda_oe_out, scl_oe_out});
        for (int i = 0; i < 7; i++) rdc(12'(i * 4), 32'h0);
        clk_en_in <= 1'b0;
        psel_in <= 1'b1;
        pwrite_in <= 1'b1;
        paddr_in <= `IPSC_OFF_RELOAD;
        pwdata_in <= 32'h33;
        @(posedge clk_in);
        penable_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("frozen ready", 32'h0, {31'h0, pready_out});
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        clk_en_in <= 1'b1;
        @(posedge clk_in);
        rdc(`IPSC_OFF_RELOAD, 32'h0);
        $display("reset and freeze done");
        final_report();
    end
endmodule
